// ==== ccpcu_far_model.sv ====
`timescale 1ns/100ps
// Far side of the unit: event timer clock, capture source, converter and the pin wire.
module ccpcu_far_model (
	// Clock.
	input wire logic mclk,
	// Unit outputs seen by the far side.
	input wire logic adc_start,
	input wire logic cap_event,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	// Stimulus towards the unit.
	output logic evt_tick,
	output logic cap_pin,
	// Observed pin level.
	output logic pin_wire
);
	int adc_cnt = 0;
	int cap_cnt = 0;
	logic last_q = 1'b0;

	initial begin
		evt_tick = 1'b0;
		cap_pin = 1'b0;
	end

	// The pin has no pull, so an undriven wire shows the inverse of its last value.
	always @(posedge mclk) begin
		if (!pin_oe_n) begin
			last_q <= pin_out;
		end
		if (adc_start === 1'b1) begin
			adc_cnt <= adc_cnt + 1;
		end
		if (cap_event === 1'b1) begin
			cap_cnt <= cap_cnt + 1;
		end
	end
	assign pin_wire = pin_oe_n ? ~last_q : pin_out;

	// Ticks come from the system clock domain, as a synchronised timer would make them.
	task automatic tick();
		evt_tick = 1'b1;
		@(posedge mclk);
		#1;
		evt_tick = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	// Slow rising edges so the three-stage synchroniser sees every one.
	task automatic cap_edges(input int n);
		repeat (n) begin
			cap_pin = 1'b1;
			repeat (4) @(posedge mclk);
			#1;
			cap_pin = 1'b0;
			repeat (4) @(posedge mclk);
			#1;
		end
	endtask
endmodule

// ==== ccpcu_pkg.sv ====
package ccpcu_pkg;

	// Mode field encodings of the unit control register.
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR = 4'h9;
	localparam logic [3:0] MODE_CMP_SWI = 4'hA;
	localparam logic [3:0] MODE_CMP_SEV = 4'hB;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;

	// Field positions inside the unit control register.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_MSB = 3;
	localparam int CTRL_DUTY_LSB = 4;
	localparam int CTRL_DUTY_MSB = 5;

	// Reset values and the event timer maximum.
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	localparam logic [15:0] EVT_TMR_RST = 16'h0000;
	localparam logic [15:0] EVT_TMR_MAX = 16'hFFFF;

	// Period timer prescale codes and the last count of each prescaler.
	localparam logic [1:0] PRESC_1 = 2'h0;
	localparam logic [1:0] PRESC_4 = 2'h1;
	localparam logic [3:0] PRESC_LAST_1 = 4'h0;
	localparam logic [3:0] PRESC_LAST_4 = 4'h3;
	localparam logic [3:0] PRESC_LAST_16 = 4'hF;

	// Oscillator periods per instruction cycle, last phase of the phase counter.
	localparam logic [1:0] OSC_PHASE_LAST = 2'h3;

	// Capture prescaler last counts: every edge, every 4th, every 16th.
	localparam logic [3:0] CAP_LAST_1 = 4'h0;
	localparam logic [3:0] CAP_LAST_4 = 4'h3;
	localparam logic [3:0] CAP_LAST_16 = 4'hF;

	// True for the four capture modes.
	function automatic logic is_capture(input logic [3:0] mode);
		is_capture = (mode[3:2] == 2'h1);
	endfunction

	// True for the modes that compare against the event timer.
	function automatic logic is_compare(input logic [3:0] mode);
		is_compare = (mode == MODE_TOGGLE) || (mode[3:2] == 2'h2);
	endfunction

endpackage

// ==== ccpcu_unit.sv ====
`timescale 1ns/100ps
// Contract
// - Capture prescaler counter stays cleared when off or not in capture mode.
// - Every reset clears the capture prescaler counter.
// - Prescale changes do not clear the counter; software writes zero first.
// - Compare mode matches the 16-bit compare value against the event timer.
// - A match toggles, sets or clears the pin, triggers, or only interrupts.
// - Every compare mode sets the match interrupt flag on a match.
// - Writing zero to control forces the compare output latch low.
// - Software interrupt compare mode leaves the pin alone.
// - Special event resets the event timer, starts conversion, leaves pin alone.
// - Trigger leaves immediately; timer clears at the next timer tick.
// - Special event timer reset never sets the overflow flag.
// - If the match disappears before that tick, no timer reset happens.
// - PWM period is (period+1) times four oscillator periods times prescale.
// - After period match: clear timer, set pin unless duty zero, load duty.
// - The period timer postscaler has no effect on the PWM period.
// - Duty is low register as upper eight bits plus two control bits.
// - Duty double buffered, loaded at period end; high register read-only.
// - Time base is period timer plus phase, prescaler low bits, or prescaler top bits at 1:16.
// - Time base equal to buffered duty drives the pin low.
// - Duty beyond the period never clears the pin.
// - Resolution is log2 of four times period plus one.
// - Mode zero switches the unit off and resets its state.
module ccpcu_unit (
	// Clock and reset.
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Register writes.
	input wire logic CTRL_WR,
	input wire logic [5:0] CTRL_WDATA,
	input wire logic CMP_LO_WR,
	input wire logic CMP_HI_WR,
	input wire logic [7:0] CMP_WDATA,
	input wire logic PERIOD_WR,
	input wire logic [7:0] PERIOD_WDATA,
	// Period timer control and surrounding bits.
	input wire logic PTMR_ON,
	input wire logic [1:0] PTMR_PRESC,
	input wire logic ADC_ENABLE,
	input wire logic PIN_DIRECTION_BIT,
	input wire logic CAP_PIN,
	// Event timer increment and flag clears.
	input wire logic EVT_TICK,
	input wire logic EVT_OVF_CLR,
	input wire logic MATCH_CLR,
	// Pin.
	output logic UNIT_PIN_OUT,
	output logic UNIT_PIN_OE_N,
	// Flags and events.
	output logic MATCH_INTERRUPT_FLAG,
	output logic TIMER_OVERFLOW_FLAG,
	output logic ADC_START,
	output logic CAP_EVENT,
	// Readback.
	output logic [5:0] CTRL_RDATA,
	output logic [7:0] CMP_LO_RDATA,
	output logic [7:0] CMP_HI_RDATA,
	output logic [15:0] EVENT_TIMER_COUNT,
	output logic [7:0] PERIOD_TIMER_COUNT,
	output logic [3:0] PWM_RESOLUTION
);

	// Floor of log2 of four times (period + 1).
	function automatic logic [3:0] res_bits(input logic [7:0] period);
		logic [10:0] span;
		logic [3:0] r;
		span = {({1'b0, period} + 9'h001), 2'h0};
		r = 4'h0;
		for (int i = 0; i < 11; i++) begin
			if (span[i]) begin
				r = 4'(i);
			end
		end
		res_bits = r;
	endfunction

	logic [5:0] unit_control_register_q;
	logic [7:0] compare_low_duty_upper_q;
	logic [7:0] compare_high_duty_buffer_q;
	logic [1:0] duty_latch_q;
	logic [7:0] period_limit_register_q;
	logic [15:0] sixteen_bit_event_timer_q;
	logic [7:0] eight_bit_period_timer_q;
	logic [3:0] ptmr_presc_q;
	logic [1:0] osc_phase_q;
	logic [3:0] cap_presc_q;
	logic cap_s1_q, cap_s2_q, cap_s3_q;
	logic cnt_upd_q;
	logic sev_pend_q;
	logic cmp_latch_q;
	logic pwm_q;
	logic [3:0] unit_mode_field;
	logic [1:0] duty_low_bits;
	logic pwm_mode, match_now, match_evt, sev_reset, instr_en, ptmr_tick, period_end;
	logic cap_edge, pin_drives;
	logic [3:0] presc_last, cap_last;
	logic [1:0] tb_low;
	logic [9:0] time_base, duty_buf, time_base_nx;
	logic [7:0] ptmr_nx;
	logic [3:0] presc_nx;
	logic [1:0] tb_low_nx;

	// Field decode of the control register.
	assign unit_mode_field = unit_control_register_q[ccpcu_pkg::CTRL_MODE_MSB:ccpcu_pkg::CTRL_MODE_LSB];
	assign duty_low_bits = unit_control_register_q[ccpcu_pkg::CTRL_DUTY_MSB:ccpcu_pkg::CTRL_DUTY_LSB];
	assign pwm_mode = (unit_mode_field[3:2] == ccpcu_pkg::MODE_PWM_TOP);

	// Readback straight from the holding flip-flops.
	assign CTRL_RDATA = unit_control_register_q;
	assign CMP_LO_RDATA = compare_low_duty_upper_q;
	assign CMP_HI_RDATA = compare_high_duty_buffer_q;
	assign EVENT_TIMER_COUNT = sixteen_bit_event_timer_q;
	assign PERIOD_TIMER_COUNT = eight_bit_period_timer_q;

	// Control and period registers.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			unit_control_register_q <= ccpcu_pkg::CTRL_RST;
			period_limit_register_q <= ccpcu_pkg::PERIOD_RST;
		end else begin
			if (CTRL_WR) begin
				unit_control_register_q <= CTRL_WDATA;
			end
			if (PERIOD_WR) begin
				period_limit_register_q <= PERIOD_WDATA;
			end
		end
	end

	// Compare low register doubles as the upper duty bits and is writable at any time.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			compare_low_duty_upper_q <= ccpcu_pkg::CMP_RST;
		end else if (CMP_LO_WR) begin
			compare_low_duty_upper_q <= CMP_WDATA;
		end
	end

	// High register is the duty buffer in PWM; software writes are dropped there.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			compare_high_duty_buffer_q <= ccpcu_pkg::CMP_RST;
			duty_latch_q <= 2'h0;
		end else if (pwm_mode) begin
			if (period_end) begin
				compare_high_duty_buffer_q <= compare_low_duty_upper_q;
				duty_latch_q <= duty_low_bits;
			end
		end else if (CMP_HI_WR) begin
			compare_high_duty_buffer_q <= CMP_WDATA;
		end
	end

	// Four oscillator periods make one instruction cycle.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			osc_phase_q <= 2'h0;
		end else begin
			osc_phase_q <= osc_phase_q + 2'h1;
		end
	end
	assign instr_en = (osc_phase_q == ccpcu_pkg::OSC_PHASE_LAST);

	// Prescale select; no postscaler exists, so the period only sees this.
	always_comb begin
		presc_last = ccpcu_pkg::PRESC_LAST_16;
		tb_low = ptmr_presc_q[3:2];
		if (PTMR_PRESC == ccpcu_pkg::PRESC_1) begin
			presc_last = ccpcu_pkg::PRESC_LAST_1;
			tb_low = osc_phase_q;
		end else if (PTMR_PRESC == ccpcu_pkg::PRESC_4) begin
			presc_last = ccpcu_pkg::PRESC_LAST_4;
			tb_low = ptmr_presc_q[1:0];
		end
	end
	assign ptmr_tick = PTMR_ON && instr_en && (ptmr_presc_q >= presc_last);
	assign period_end = ptmr_tick && (eight_bit_period_timer_q == period_limit_register_q);
	assign time_base = {eight_bit_period_timer_q, tb_low};
	assign duty_buf = {compare_high_duty_buffer_q, duty_latch_q};

	// Time base after this edge; matching it clears the output on entry, not a cycle late.
	always_comb begin
		presc_nx = ptmr_presc_q;
		ptmr_nx = eight_bit_period_timer_q;
		if (PTMR_ON && instr_en) begin
			presc_nx = ptmr_tick ? 4'h0 : ptmr_presc_q + 4'h1;
			if (period_end) begin
				ptmr_nx = 8'h00;
			end else if (ptmr_tick) begin
				ptmr_nx = eight_bit_period_timer_q + 8'h01;
			end
		end
		tb_low_nx = presc_nx[3:2];
		if (PTMR_PRESC == ccpcu_pkg::PRESC_1) begin
			tb_low_nx = osc_phase_q + 2'h1;
		end else if (PTMR_PRESC == ccpcu_pkg::PRESC_4) begin
			tb_low_nx = presc_nx[1:0];
		end
		time_base_nx = {ptmr_nx, tb_low_nx};
	end

	// Period timer and its prescaler; the timer wraps on the tick after the limit.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ptmr_presc_q <= 4'h0;
			eight_bit_period_timer_q <= 8'h00;
		end else if (PTMR_ON && instr_en) begin
			if (ptmr_tick) begin
				ptmr_presc_q <= 4'h0;
				if (period_end) begin
					eight_bit_period_timer_q <= 8'h00;
				end else begin
					eight_bit_period_timer_q <= eight_bit_period_timer_q + 8'h01;
				end
			end else begin
				ptmr_presc_q <= ptmr_presc_q + 4'h1;
			end
		end
	end

	// PWM output; period end has priority over the duty match in the same cycle.
	always_ff @(posedge MCLK) begin
		if (SYS_RST || !pwm_mode) begin
			pwm_q <= 1'b0;
		end else if (period_end) begin
			pwm_q <= ({compare_low_duty_upper_q, duty_low_bits} != 10'h000);
		end else if ((time_base_nx == duty_buf) || (time_base == duty_buf)) begin
			pwm_q <= 1'b0;
		end
	end

	AST_PERIOD_END: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(pwm_mode && period_end) |=> (eight_bit_period_timer_q == 8'h00) &&
		(compare_high_duty_buffer_q == $past(compare_low_duty_upper_q)))
		else $error("Period end did not clear the timer or load the duty.");

	AST_DUTY_CLEAR: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(pwm_mode && !period_end && (time_base == duty_buf)) |=> !pwm_q)
		else $error("Duty match did not drive the output low.");

	AST_HI_READ_ONLY: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(pwm_mode && CMP_HI_WR && !period_end) |=> $stable(compare_high_duty_buffer_q))
		else $error("High register changed by a write during PWM.");

	// Compare is sampled once, in the cycle after each timer increment.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			cnt_upd_q <= 1'b0;
		end else begin
			cnt_upd_q <= EVT_TICK;
		end
	end
	assign match_now = (sixteen_bit_event_timer_q ==
		{compare_high_duty_buffer_q, compare_low_duty_upper_q});
	assign match_evt = cnt_upd_q && match_now && ccpcu_pkg::is_compare(unit_mode_field);
	assign sev_reset = EVT_TICK && sev_pend_q && match_now;

	// Event timer; a pending special event whose match still holds replaces the next increment with a clear.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			sixteen_bit_event_timer_q <= ccpcu_pkg::EVT_TMR_RST;
		end else if (sev_reset) begin
			sixteen_bit_event_timer_q <= ccpcu_pkg::EVT_TMR_RST;
		end else if (EVT_TICK) begin
			sixteen_bit_event_timer_q <= sixteen_bit_event_timer_q + 16'h0001;
		end
	end

	// Overflow flag; a new overflow wins over a clear in the same cycle.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			TIMER_OVERFLOW_FLAG <= 1'b0;
		end else if (EVT_TICK && !sev_reset &&
			(sixteen_bit_event_timer_q == ccpcu_pkg::EVT_TMR_MAX)) begin
			TIMER_OVERFLOW_FLAG <= 1'b1;
		end else if (EVT_OVF_CLR) begin
			TIMER_OVERFLOW_FLAG <= 1'b0;
		end
	end

	// Special event: the trigger leaves at once, the timer clear waits for a tick.
	always_ff @(posedge MCLK) begin
		if (SYS_RST || (unit_mode_field != ccpcu_pkg::MODE_CMP_SEV)) begin
			sev_pend_q <= 1'b0;
			ADC_START <= 1'b0;
		end else begin
			ADC_START <= match_evt && ADC_ENABLE;
			if (match_evt) begin
				sev_pend_q <= 1'b1;
			end else if (EVT_TICK) begin
				sev_pend_q <= 1'b0;
			end
		end
	end

	AST_SEV_ADC: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(match_evt && ADC_ENABLE && (unit_mode_field == ccpcu_pkg::MODE_CMP_SEV)) |=> ADC_START)
		else $error("Special event did not start a conversion.");

	AST_SEV_NO_OVF: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(sev_reset && !TIMER_OVERFLOW_FLAG) |=>
		(sixteen_bit_event_timer_q == 16'h0000) && !TIMER_OVERFLOW_FLAG)
		else $error("Special event reset missed or set the overflow flag.");

	AST_SEV_CANCEL: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(EVT_TICK && sev_pend_q && !match_now && (sixteen_bit_event_timer_q != 16'hFFFF)) |=>
		(sixteen_bit_event_timer_q == $past(sixteen_bit_event_timer_q) + 16'h0001))
		else $error("Timer reset despite the vanished match.");

	// Match flag is sticky; a match in the clearing cycle keeps it set.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			MATCH_INTERRUPT_FLAG <= 1'b0;
		end else if (match_evt) begin
			MATCH_INTERRUPT_FLAG <= 1'b1;
		end else if (MATCH_CLR) begin
			MATCH_INTERRUPT_FLAG <= 1'b0;
		end
	end

	AST_MATCH_FLAG: assert property (@(posedge MCLK) disable iff (SYS_RST)
		match_evt |=> MATCH_INTERRUPT_FLAG)
		else $error("Compare match did not set the match flag.");

	// Compare output latch; a zero write or the off mode forces it low.
	always_ff @(posedge MCLK) begin
		if (SYS_RST || (unit_mode_field == ccpcu_pkg::MODE_OFF) ||
			(CTRL_WR && (CTRL_WDATA == 6'h00))) begin
			cmp_latch_q <= 1'b0;
		end else if (match_evt) begin
			case (unit_mode_field)
				ccpcu_pkg::MODE_TOGGLE: begin
					cmp_latch_q <= !cmp_latch_q;
				end
				ccpcu_pkg::MODE_CMP_SET: begin
					cmp_latch_q <= 1'b1;
				end
				ccpcu_pkg::MODE_CMP_CLR: begin
					cmp_latch_q <= 1'b0;
				end
				default: begin
					cmp_latch_q <= cmp_latch_q;
				end
			endcase
		end
	end

	AST_ZERO_WRITE: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(CTRL_WR && (CTRL_WDATA == 6'h00)) |=> !cmp_latch_q ##1 !UNIT_PIN_OUT)
		else $error("Zero control write left the compare latch high.");

	// Pin ownership; the port direction bit still gates the driver.
	assign pin_drives = pwm_mode || (unit_mode_field == ccpcu_pkg::MODE_TOGGLE) ||
		(unit_mode_field == ccpcu_pkg::MODE_CMP_SET) ||
		(unit_mode_field == ccpcu_pkg::MODE_CMP_CLR);
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			UNIT_PIN_OE_N <= 1'b1;
			UNIT_PIN_OUT <= 1'b0;
		end else begin
			UNIT_PIN_OE_N <= !(pin_drives && !PIN_DIRECTION_BIT);
			UNIT_PIN_OUT <= pin_drives && (pwm_mode ? pwm_q : cmp_latch_q);
		end
	end

	AST_SWI_NO_PIN: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(unit_mode_field == ccpcu_pkg::MODE_CMP_SWI) |=> UNIT_PIN_OE_N)
		else $error("Software interrupt mode drove the pin.");

	AST_SEV_NO_PIN: assert property (@(posedge MCLK) disable iff (SYS_RST)
		(unit_mode_field == ccpcu_pkg::MODE_CMP_SEV) |=> UNIT_PIN_OE_N && !UNIT_PIN_OUT)
		else $error("Special event mode drove the pin.");

	// Capture pin synchroniser; only the second and third stages feed the edge detector.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			cap_s3_q <= 1'b0;
		end else begin
			cap_s1_q <= CAP_PIN;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	// Edge selection and prescale per capture mode.
	always_comb begin
		cap_edge = !cap_s3_q && cap_s2_q;
		cap_last = ccpcu_pkg::CAP_LAST_1;
		case (unit_mode_field)
			ccpcu_pkg::MODE_CAP_FALL: begin
				cap_edge = cap_s3_q && !cap_s2_q;
			end
			ccpcu_pkg::MODE_CAP_RISE4: begin
				cap_last = ccpcu_pkg::CAP_LAST_4;
			end
			ccpcu_pkg::MODE_CAP_RISE16: begin
				cap_last = ccpcu_pkg::CAP_LAST_16;
			end
			default: begin
				cap_last = ccpcu_pkg::CAP_LAST_1;
			end
		endcase
	end

	// Prescaler counter; switching prescale keeps its count, which may fire early.
	always_ff @(posedge MCLK) begin
		if (SYS_RST || !ccpcu_pkg::is_capture(unit_mode_field)) begin
			cap_presc_q <= 4'h0;
			CAP_EVENT <= 1'b0;
		end else if (cap_edge && (cap_presc_q >= cap_last)) begin
			cap_presc_q <= 4'h0;
			CAP_EVENT <= 1'b1;
		end else begin
			cap_presc_q <= cap_presc_q + {3'h0, cap_edge};
			CAP_EVENT <= 1'b0;
		end
	end

	AST_PRESC_OFF: assert property (@(posedge MCLK) disable iff (SYS_RST)
		!ccpcu_pkg::is_capture(unit_mode_field) |=> (cap_presc_q == 4'h0) && !CAP_EVENT)
		else $error("Capture prescaler not cleared outside capture mode.");

	AST_PRESC_RST: assert property (@(posedge MCLK)
		SYS_RST |=> (cap_presc_q == 4'h0))
		else $error("Reset did not clear the capture prescaler.");

	// Resolution readout follows the period register.
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			PWM_RESOLUTION <= res_bits(ccpcu_pkg::PERIOD_RST);
		end else begin
			PWM_RESOLUTION <= res_bits(period_limit_register_q);
		end
	end

endmodule

// ==== ccpcu_unit_tb_top.sv ====
`timescale 1ns/100ps
// Directed bench: register writes, compare matches and PWM waveform measurement.
module ccpcu_unit_tb_top;
	logic MCLK = 1'b0, SYS_RST = 1'b1;
	logic CTRL_WR = 1'b0, CMP_LO_WR = 1'b0, CMP_HI_WR = 1'b0, PERIOD_WR = 1'b0;
	logic [5:0] CTRL_WDATA = 6'h00;
	logic [7:0] CMP_WDATA = 8'h00, PERIOD_WDATA = 8'h00;
	logic PTMR_ON = 1'b0, ADC_ENABLE = 1'b1, PIN_DIRECTION_BIT = 1'b0;
	logic [1:0] PTMR_PRESC = 2'h0;
	logic EVT_OVF_CLR = 1'b0, MATCH_CLR = 1'b0;
	logic CAP_PIN, EVT_TICK, UNIT_PIN_OUT, UNIT_PIN_OE_N, MATCH_INTERRUPT_FLAG;
	logic TIMER_OVERFLOW_FLAG, ADC_START, CAP_EVENT, pin_wire;
	logic [5:0] CTRL_RDATA;
	logic [7:0] CMP_LO_RDATA, CMP_HI_RDATA, PERIOD_TIMER_COUNT;
	logic [15:0] EVENT_TIMER_COUNT;
	logic [3:0] PWM_RESOLUTION;
	int failures = 0, tests_run = 0, cycles = 0;
	logic [15:0] ev = 16'h0000;

	ccpcu_unit dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .CTRL_WR(CTRL_WR),
		.CTRL_WDATA(CTRL_WDATA), .CMP_LO_WR(CMP_LO_WR), .CMP_HI_WR(CMP_HI_WR),
		.CMP_WDATA(CMP_WDATA), .PERIOD_WR(PERIOD_WR), .PERIOD_WDATA(PERIOD_WDATA),
		.PTMR_ON(PTMR_ON), .PTMR_PRESC(PTMR_PRESC), .ADC_ENABLE(ADC_ENABLE),
		.PIN_DIRECTION_BIT(PIN_DIRECTION_BIT), .CAP_PIN(CAP_PIN), .EVT_TICK(EVT_TICK),
		.EVT_OVF_CLR(EVT_OVF_CLR), .MATCH_CLR(MATCH_CLR), .UNIT_PIN_OUT(UNIT_PIN_OUT),
		.UNIT_PIN_OE_N(UNIT_PIN_OE_N), .MATCH_INTERRUPT_FLAG(MATCH_INTERRUPT_FLAG),
		.TIMER_OVERFLOW_FLAG(TIMER_OVERFLOW_FLAG), .ADC_START(ADC_START),
		.CAP_EVENT(CAP_EVENT), .CTRL_RDATA(CTRL_RDATA), .CMP_LO_RDATA(CMP_LO_RDATA),
		.CMP_HI_RDATA(CMP_HI_RDATA), .EVENT_TIMER_COUNT(EVENT_TIMER_COUNT),
		.PERIOD_TIMER_COUNT(PERIOD_TIMER_COUNT), .PWM_RESOLUTION(PWM_RESOLUTION));

	ccpcu_far_model far_u (.mclk(MCLK), .adc_start(ADC_START), .cap_event(CAP_EVENT),
		.pin_out(UNIT_PIN_OUT), .pin_oe_n(UNIT_PIN_OE_N), .evt_tick(EVT_TICK),
		.cap_pin(CAP_PIN), .pin_wire(pin_wire));

	// Free-running 100 MHz system clock.
	initial begin
		forever #5 MCLK = ~MCLK;
	end

	// Hang guard, sized well above the roughly two thousand cycles the sequence needs.
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask

	// One strobe cycle; 0 control, 1 low, 2 high, 3 period, 4 match flag clear.
	task automatic wr(input int sel, input logic [7:0] d);
		CTRL_WDATA = d[5:0];
		CMP_WDATA = d;
		PERIOD_WDATA = d;
		case (sel)
			0: CTRL_WR = 1'b1;
			1: CMP_LO_WR = 1'b1;
			2: CMP_HI_WR = 1'b1;
			3: PERIOD_WR = 1'b1;
			default: MATCH_CLR = 1'b1;
		endcase
		cyc(1);
		{CTRL_WR, CMP_LO_WR, CMP_HI_WR, PERIOD_WR, MATCH_CLR} = 5'h00;
		cyc(1);
	endtask

	// Arm a compare mode, tick up to the match and look at flag, pin and ownership.
	task automatic cmp_step(input logic [3:0] m, input logic [7:0] c, input int n,
		input logic pin, input logic oe_n);
		wr(1, c);
		wr(2, 8'h00);
		wr(0, {4'h0, m});
		wr(4, 8'h00);
		repeat (n) begin
			far_u.tick();
			ev++;
		end
		chk(EVENT_TIMER_COUNT, ev, "timer");
		chk(MATCH_INTERRUPT_FLAG, 1'b1, "flag");
		chk(UNIT_PIN_OUT, pin, "pin");
		chk(UNIT_PIN_OE_N, oe_n, "oe");
	endtask

	// Measure high time over two whole periods after the new duty has been loaded.
	task automatic pwm(input logic [1:0] p, input logic [7:0] lo, input logic [1:0] db);
		int ps, per, hi, w;
		ps = (p == 2'h0) ? 1 : (p == 2'h1) ? 4 : 16;
		per = 4 * (3 + 1) * ps;
		w = {lo, db} * ps;
		hi = 0;
		PTMR_PRESC = p;
		wr(1, lo);
		wr(0, {db, 4'hC});
		cyc(2 * per);
		wr(2, 8'hAA);
		chk(CMP_HI_RDATA, lo, "duty buffer");
		chk(CMP_LO_RDATA, lo, "duty upper");
		repeat (2 * per) begin
			if (pin_wire === 1'b1) begin
				hi++;
			end
			cyc(1);
		end
		chk(hi, 2 * ((w > per) ? per : w), "high time");
	endtask

	initial begin
		repeat (12) @(posedge MCLK);
		#1;
		SYS_RST = 1'b0;
		cyc(1);
		chk(CTRL_RDATA, 6'h00, "ctrl reset");
		chk({UNIT_PIN_OE_N, UNIT_PIN_OUT}, 2'h2, "pin reset");
		chk(PWM_RESOLUTION, 4'hA, "resolution reset");
		chk(PERIOD_TIMER_COUNT, 8'h00, "period timer reset");
		wr(0, 8'h06);
		far_u.cap_edges(4);
		chk(far_u.cap_cnt, 1, "capture every 4th");
		far_u.cap_edges(2);
		wr(0, 8'h08);
		wr(0, 8'h06);
		far_u.cap_edges(2);
		chk(far_u.cap_cnt, 1, "prescaler cleared");
		far_u.cap_edges(2);
		chk(far_u.cap_cnt, 2, "capture after clear");
		wr(0, 8'h05);
		far_u.cap_edges(1);
		chk(far_u.cap_cnt, 3, "capture every edge");
		wr(0, 8'h04);
		far_u.cap_edges(1);
		chk(far_u.cap_cnt, 4, "capture falling edge");
		wr(0, 8'h07);
		far_u.cap_edges(5);
		wr(0, 8'h06);
		far_u.cap_edges(1);
		chk(far_u.cap_cnt, 5, "prescale switch keeps count");
		wr(0, 8'h07);
		far_u.cap_edges(15);
		chk(far_u.cap_cnt, 5, "capture every 16th early");
		far_u.cap_edges(1);
		chk(far_u.cap_cnt, 6, "capture every 16th");
		cmp_step(4'h8, 8'h03, 3, 1'b1, 1'b0);
		cmp_step(4'h9, 8'h05, 2, 1'b0, 1'b0);
		cmp_step(4'h2, 8'h07, 2, 1'b1, 1'b0);
		wr(0, 8'h00);
		chk({UNIT_PIN_OE_N, UNIT_PIN_OUT}, 2'h2, "zero write");
		cmp_step(4'hA, 8'h09, 2, 1'b0, 1'b1);
		cmp_step(4'hB, 8'h0B, 2, 1'b0, 1'b1);
		chk(far_u.adc_cnt, 1, "conversion start");
		far_u.tick();
		ev = 16'h0000;
		chk(EVENT_TIMER_COUNT, ev, "special reset");
		chk(TIMER_OVERFLOW_FLAG, 1'b0, "no overflow");
		wr(1, 8'h02);
		far_u.tick();
		far_u.tick();
		ev = 16'h0002;
		chk(far_u.adc_cnt, 2, "second trigger");
		wr(1, 8'h09);
		far_u.tick();
		ev++;
		chk(EVENT_TIMER_COUNT, ev, "reset withdrawn");
		wr(3, 8'h03);
		chk(PWM_RESOLUTION, 4'h4, "resolution");
		PTMR_ON = 1'b1;
		pwm(2'h0, 8'h01, 2'h2);
		chk(UNIT_PIN_OE_N, 1'b0, "pwm owns pin");
		pwm(2'h1, 8'h01, 2'h2);
		pwm(2'h2, 8'h01, 2'h2);
		pwm(2'h0, 8'h00, 2'h0);
		pwm(2'h0, 8'h05, 2'h0);
		PIN_DIRECTION_BIT = 1'b1;
		cyc(3);
		chk(UNIT_PIN_OE_N, 1'b1, "direction input");
		stop_test();
	end
endmodule
